// File: src/udc_top.sv
// dma channel control: wishbone registers, four channels, interrupt
`timescale 1ns/10ps
`default_nettype none
module udc_top
    import udc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [DAT_W-1:0]      wb_dat_i,
    output logic      [DAT_W-1:0]      wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       irq_o,
    input  wire logic [TX_N-1:0]       tx_partial_det,
    input  wire logic [TX_N-1:0]       tx_count_zero,
    input  wire logic [TX_N-1:0]       tx_timeout,
    input  wire logic [RX_N-1:0]       rx_count_zero,
    input  wire logic [RX_N-1:0]       rx_uart_err,
    input  wire logic [RX_N-1:0]       rx_timeout,
    input  wire logic [CH_N-1:0]       ubm_sel_we,
    input  wire logic [CH_N-1:0]       ubm_sel_val,
    output logic      [CH_N-1:0]       chan_en_o,
    output logic      [CH_N-1:0]       chan_cont_o,
    output logic      [CH_N-1:0]       chan_sel_o,
    output logic      [CH_N*PTR_W-1:0] chan_ptr_o,
    output logic      [CH_N-1:0]       descr_update_o
);
    logic             ack_r;
    logic [DAT_W-1:0] dat_r;
    logic [3:0]       irq_stat_r;
    logic [3:0]       irq_stat_nxt;
    logic [3:0]       irq_mask_r;
    logic             irq_r;
    logic [REG_W-1:0] def_val [CH_N];
    logic [REG_W-1:0] stat_val [TX_N];
    logic [CH_N-1:0]  def_hit;
    logic [CH_N-1:0]  def_we;
    logic [CH_N-1:0]  ch_ine;
    logic [CH_N-1:0]  ch_stop;
    logic [CH_N-1:0]  ch_supp;
    logic [CH_N-1:0]  ch_sel_we;
    logic [CH_N-1:0]  ch_sel_wd;
    logic [CH_N-1:0]  ch_irq_ev;
    logic [TX_N-1:0]  stat_hit;
    logic [TX_N-1:0]  stat_we;
    logic [TX_N-1:0]  tx_partial_packet_flag;
    logic [TX_N-1:0]  tx_tmo;
    logic [REG_W-1:0] rd_or [CH_N+TX_N+1];
    logic             req;
    logic             wr_fire;
    logic             irq_stat_hit;
    logic             irq_mask_hit;
    logic             comp_hit;
    logic [REG_W-1:0] rd_mux;

    // bus request and write strobe; a write lands on the edge the master
    // samples ack, so the register never changes ahead of the handshake
    assign req     = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & wb_we_i & ack_r & wb_sel_i[0];

    // address decode of the fixed registers
    assign irq_stat_hit = wb_adr_i[7:2] == OFS_IRQ_STAT[7:2];
    assign irq_mask_hit = wb_adr_i[7:2] == OFS_IRQ_MASK[7:2];
    assign comp_hit     = wb_adr_i[7:2] == OFS_TX_COMP[7:2];

    // per channel: decode, register and halt conditions
    generate
        for (genvar g = 0; g < CH_N; g++) begin : g_ch
            assign def_hit[g] = wb_adr_i[7:2] == OFS_DEF0[7:2] + 6'(g);
            assign def_we[g]  = wr_fire & def_hit[g];
            assign rd_or[g+1] = rd_or[g] | (def_hit[g] ? def_val[g] : 8'h00);
            if (g < TX_N) begin : g_tx
                // without the interrupt the channel rides over errors
                assign ch_stop[g] = tx_count_zero[g] |
                                    (ch_ine[g] & (tx_partial_det[g] |
                                                  tx_timeout[g]));
                assign ch_supp[g]   = 1'b0;
                assign ch_sel_we[g] = stat_we[g];
                assign ch_sel_wd[g] = wb_dat_i[BIT_XY];
            end else begin : g_rx
                assign ch_stop[g] = (~chan_cont_o[g] &
                                     rx_count_zero[g-TX_N]) |
                                    rx_uart_err[g-TX_N] |
                                    (ch_ine[g] & rx_timeout[g-TX_N]);
                // the uart reports its own error; no dma interrupt
                assign ch_supp[g]   = rx_uart_err[g-TX_N];
                assign ch_sel_we[g] = 1'b0;
                assign ch_sel_wd[g] = 1'b0;
            end
            udc_def_reg u_def (
                .clk          (clk),
                .reset_n      (reset_n),
                .reg_we       (def_we[g]),
                .reg_wdata    (wb_dat_i[REG_W-1:0]),
                .sel_we       (ch_sel_we[g]),
                .sel_wdata    (ch_sel_wd[g]),
                .ubm_sel_we   (ubm_sel_we[g]),
                .ubm_sel_val  (ubm_sel_val[g]),
                .stop_req     (ch_stop[g]),
                .irq_suppress (ch_supp[g]),
                .def_val      (def_val[g]),
                .en           (chan_en_o[g]),
                .completion_irq_enable          (ch_ine[g]),
                .cont         (chan_cont_o[g]),
                .buf_sel      (chan_sel_o[g]),
                .ptr          (chan_ptr_o[g*PTR_W +: PTR_W]),
                .irq_event    (ch_irq_ev[g]),
                .descr_update (descr_update_o[g])
            );
        end
        for (genvar t = 0; t < TX_N; t++) begin : g_st
            assign stat_hit[t] = wb_adr_i[7:2] == OFS_TX_STAT0[7:2] + 6'(t);
            assign stat_we[t]  = wr_fire & stat_hit[t];
            assign rd_or[CH_N+t+1] = rd_or[CH_N+t] |
                                     (stat_hit[t] ? stat_val[t] : 8'h00);
            udc_tx_stat u_stat (
                .clk          (clk),
                .reset_n      (reset_n),
                .stat_we      (stat_we[t]),
                .partial_packet_flag_clr     (wb_dat_i[BIT_PARTIAL_PACKET_FLAG]),
                .comp_clr     (wr_fire & comp_hit & wb_dat_i[t]),
                .partial_det  (tx_partial_det[t]),
                .timeout_det  (tx_timeout[t]),
                .buf_sel      (chan_sel_o[t]),
                .stat_val     (stat_val[t]),
                .partial_packet_flag         (tx_partial_packet_flag[t]),
                .timeout_flag (tx_tmo[t])
            );
        end
    endgenerate

    // read selection; unmapped addresses read zero
    assign rd_or[0] = 8'h00;
    assign rd_mux = rd_or[CH_N+TX_N] |
                    (irq_stat_hit ? {4'h0, irq_stat_r} : 8'h00) |
                    (irq_mask_hit ? {4'h0, irq_mask_r} : 8'h00) |
                    (comp_hit ? {6'h00, tx_tmo} : 8'h00);

    // sticky events; a new event outranks a write-one clear
    assign irq_stat_nxt = ch_irq_ev |
        (irq_stat_r & ~((wr_fire & irq_stat_hit) ? wb_dat_i[3:0] : 4'h0));

    // bus answer: ack one cycle after the request, dropped the next
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            dat_r <= (req & ~ack_r) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // interrupt status, mask and the level output
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_r <= IRQ_RST;
            irq_mask_r <= IRQ_RST;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_fire & irq_mask_hit) begin
                irq_mask_r <= wb_dat_i[3:0];
            end
            irq_r <= |(irq_stat_nxt &
                       ((wr_fire & irq_mask_hit) ? wb_dat_i[3:0] : irq_mask_r));
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o    = irq_r;

    // checks on the channel behaviour
    a_partial_packet_flag_sets: assert property (@(posedge clk) disable iff (!reset_n)
        tx_partial_det[0] |=> tx_partial_packet_flag[0])
        else $error("partial packet flag not set");

    a_partial_packet_flag_w1c: assert property (@(posedge clk) disable iff (!reset_n)
        stat_we[0] && wb_dat_i[0] && !tx_partial_det[0] |=> !tx_partial_packet_flag[0])
        else $error("partial packet flag not cleared by one");

    a_partial_packet_flag_w0_keeps: assert property (@(posedge clk) disable iff (!reset_n)
        stat_we[0] && !wb_dat_i[0] && tx_partial_packet_flag[0] |=> tx_partial_packet_flag[0])
        else $error("partial packet flag lost on zero write");

    a_en_kept_noine: assert property (@(posedge clk) disable iff (!reset_n)
        chan_en_o[0] && !ch_ine[0] && tx_partial_det[0] &&
        !tx_count_zero[0] && !def_we[0] |=> chan_en_o[0])
        else $error("partial packet disabled channel without interrupt");

    a_short_pkt_code: assert property (@(posedge clk) disable iff (!reset_n)
        tx_partial_det[1] && !tx_timeout[1] |=> tx_partial_packet_flag[1] && !tx_tmo[1])
        else $error("short packet completion code wrong");

    a_sel_mirror: assert property (@(posedge clk) disable iff (!reset_n)
        stat_we[0] && !chan_cont_o[0] |=>
        chan_sel_o[0] == $past(wb_dat_i[4]) && stat_val[0][4] == chan_sel_o[0])
        else $error("status select not mirrored");

    a_ptr_load: assert property (@(posedge clk) disable iff (!reset_n)
        def_we[2] |=> chan_ptr_o[8:6] == $past(wb_dat_i[2:0]))
        else $error("descriptor pointer not loaded");

    a_guard_reads: assert property (@(posedge clk) disable iff (!reset_n)
        req && !wb_we_i && |def_hit && !ack_r |=> wb_ack_o && wb_dat_o[3])
        else $error("write guard bit did not read one");

    a_guard_keeps: assert property (@(posedge clk) disable iff (!reset_n)
        def_we[3] && wb_dat_i[3] && !(chan_cont_o[3] && ubm_sel_we[3])
        |=> $stable(chan_sel_o[3]))
        else $error("guarded write changed buffer select");

    a_burst_stop: assert property (@(posedge clk) disable iff (!reset_n)
        chan_en_o[2] && !chan_cont_o[2] && rx_count_zero[0] && !def_we[2]
        |=> !chan_en_o[2] && descr_update_o[2])
        else $error("burst receive did not stop");

    a_fall_irq: assert property (@(posedge clk) disable iff (!reset_n)
        chan_en_o[2] && ch_ine[2] && rx_count_zero[0] && !chan_cont_o[2]
        && !rx_uart_err[0] && !def_we[2] |-> ##2 irq_stat_r[2])
        else $error("completion interrupt missing");

    a_cont_sel: assert property (@(posedge clk) disable iff (!reset_n)
        chan_cont_o[3] && ubm_sel_we[3] |=> chan_sel_o[3] == $past(ubm_sel_val[3]))
        else $error("buffer manager select ignored");

    a_uart_silent: assert property (@(posedge clk) disable iff (!reset_n)
        chan_en_o[3] && rx_uart_err[1] && !def_we[3] |=> !ch_irq_ev[3])
        else $error("uart error raised dma interrupt");

    a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
        irq_o == |(irq_stat_r & irq_mask_r))
        else $error("interrupt output disagrees with status");

    c_partial_packet_flag_seen: cover property (@(posedge clk) disable iff (!reset_n)
        tx_partial_det[0] ##1 tx_partial_packet_flag[0]);
    c_burst_irq: cover property (@(posedge clk) disable iff (!reset_n)
        $fell(chan_en_o[2]) ##1 irq_stat_r[2] ##1 irq_o);
    c_cont_swap: cover property (@(posedge clk) disable iff (!reset_n)
        chan_cont_o[3] && $changed(chan_sel_o[3]));
    c_read_ack: cover property (@(posedge clk) disable iff (!reset_n)
        req && !wb_we_i ##1 wb_ack_o);
endmodule
`default_nettype wire

// File: src/udc_pkg.sv
// package: register map, field positions and reset values of the dma channel control
`default_nettype none
package udc_pkg;
    // channel counts: two transmit then two receive channels
    localparam int unsigned TX_N    = 2;
    localparam int unsigned RX_N    = 2;
    localparam int unsigned CH_N    = TX_N + RX_N;
    localparam int unsigned PTR_W   = 3;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned ADR_W   = 8;
    localparam int unsigned DAT_W   = 32;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_TX_STAT0 = 8'h00; // tx status, ch0; ch1 follows
    localparam logic [7:0] OFS_DEF0     = 8'h08; // definition, ch0..ch3 follow
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_TX_COMP  = 8'h20; // tx time-out flags

    // definition register fields, then the tx status partial-packet flag bit
    localparam int unsigned BIT_EN    = 7;
    localparam int unsigned BIT_INE   = 6;
    localparam int unsigned BIT_CNT   = 5;
    localparam int unsigned BIT_XY    = 4;
    localparam int unsigned BIT_GUARD = 3;
    localparam int unsigned BIT_PARTIAL_PACKET_FLAG  = 0;

    // reset values
    localparam logic [7:0] DEF_RST   = 8'h08;
    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [3:0] IRQ_RST   = 4'h0;
    localparam logic [2:0] PTR_RST   = 3'h0;
endpackage
`default_nettype wire

// File: src/udc_def_reg.sv
// one channel definition register: enable, mode, buffer select, pointer
`timescale 1ns/10ps
`default_nettype none
module udc_def_reg
    import udc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             reg_we,
    input  wire logic [REG_W-1:0] reg_wdata,
    input  wire logic             sel_we,
    input  wire logic             sel_wdata,
    input  wire logic             ubm_sel_we,
    input  wire logic             ubm_sel_val,
    input  wire logic             stop_req,
    input  wire logic             irq_suppress,
    output logic      [REG_W-1:0] def_val,
    output logic                  en,
    output logic                  completion_irq_enable,
    output logic                  cont,
    output logic                  buf_sel,
    output logic      [PTR_W-1:0] ptr,
    output logic                  irq_event,
    output logic                  descr_update
);
    logic             en_r;
    logic             en_nxt;
    logic             ine_r;
    logic             cont_r;
    logic             xy_r;
    logic             xy_nxt;
    logic [PTR_W-1:0] ptr_r;
    logic             irq_event_r;
    logic             upd_r;
    logic             en_fall;

    // software start wins over a device halt in the same cycle
    assign en_nxt = reg_we ? reg_wdata[BIT_EN] : (stop_req ? 1'b0 : en_r);
    assign en_fall = en_r & ~en_nxt;

    // buffer manager owns the select in continuous mode; guard bit blocks the select
    // bit of definition register writes otherwise; tx status register writes are not blocked
    assign xy_nxt = (cont_r & ubm_sel_we) ? ubm_sel_val :
                    (reg_we & ~reg_wdata[BIT_GUARD]) ? reg_wdata[BIT_XY] :
                    sel_we ? sel_wdata :
                    xy_r;

    // register state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_r        <= DEF_RST[BIT_EN];
            ine_r       <= DEF_RST[BIT_INE];
            cont_r      <= DEF_RST[BIT_CNT];
            xy_r        <= DEF_RST[BIT_XY];
            ptr_r       <= PTR_RST;
            irq_event_r <= 1'b0;
            upd_r       <= 1'b0;
        end else begin
            en_r        <= en_nxt;
            xy_r        <= xy_nxt;
            irq_event_r <= en_fall & ine_r & ~irq_suppress;
            upd_r       <= en_r & stop_req & ~reg_we;
            if (reg_we) begin
                ine_r  <= reg_wdata[BIT_INE];
                cont_r <= reg_wdata[BIT_CNT];
                ptr_r  <= reg_wdata[PTR_W-1:0];
            end
        end
    end

    // guard bit is not stored: it always reads as one
    assign def_val = {en_r, ine_r, cont_r, xy_r, 1'b1, ptr_r};
    assign en           = en_r;
    assign completion_irq_enable          = ine_r;
    assign cont         = cont_r;
    assign buf_sel      = xy_r;
    assign ptr          = ptr_r;
    assign irq_event    = irq_event_r;
    assign descr_update = upd_r;
endmodule
`default_nettype wire

// File: src/udc_tx_stat.sv
// transmit status: partial-packet flag and time-out completion flag
`timescale 1ns/10ps
`default_nettype none
module udc_tx_stat
    import udc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             stat_we,
    input  wire logic             partial_packet_flag_clr,
    input  wire logic             comp_clr,
    input  wire logic             partial_det,
    input  wire logic             timeout_det,
    input  wire logic             buf_sel,
    output logic      [REG_W-1:0] stat_val,
    output logic                  partial_packet_flag,
    output logic                  timeout_flag
);
    logic partial_packet_flag_r;
    logic partial_packet_flag_nxt;
    logic tmo_r;
    logic tmo_nxt;

    // detection wins over a software clear in the same cycle
    assign partial_packet_flag_nxt = partial_det | (partial_packet_flag_r & ~(stat_we & partial_packet_flag_clr));
    // a short packet ends the transfer without a time-out code
    assign tmo_nxt = timeout_det | (tmo_r & ~partial_det & ~comp_clr);

    // flag state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            partial_packet_flag_r <= STAT_RST[BIT_PARTIAL_PACKET_FLAG];
            tmo_r  <= 1'b0;
        end else begin
            partial_packet_flag_r <= partial_packet_flag_nxt;
            tmo_r  <= tmo_nxt;
        end
    end

    // unused bits read zero; bit 4 mirrors the channel's buffer select
    assign stat_val = {3'h0, buf_sel, 3'h0, partial_packet_flag_r};
    assign partial_packet_flag         = partial_packet_flag_r;
    assign timeout_flag = tmo_r;
endmodule
`default_nettype wire

// File: testbench/udc_far_model.sv
// far-side model: buffer manager select writes and uart event pulses
`timescale 1ns/10ps
`default_nettype none
module udc_far_model (
    input  wire logic       clk,
    output logic      [1:0] tx_partial_det,
    output logic      [1:0] tx_count_zero,
    output logic      [1:0] tx_timeout,
    output logic      [1:0] rx_count_zero,
    output logic      [1:0] rx_uart_err,
    output logic      [1:0] rx_timeout,
    output logic      [3:0] ubm_sel_we,
    output logic      [3:0] ubm_sel_val
);
    logic [11:0] ev_r;
    logic [3:0]  swe_r;
    logic [3:0]  sval_r;
    logic        idle_r;

    initial begin
        ev_r   = 12'h000;
        swe_r  = 4'h0;
        sval_r = 4'h0;
        idle_r = 1'b0;
    end

    // released select lines toggle so a stale value is never mistaken
    always @(posedge clk) begin
        idle_r <= ~idle_r;
    end

    // event bits packed by kind, two channels each
    assign {rx_timeout, rx_uart_err, rx_count_zero,
            tx_timeout, tx_count_zero, tx_partial_det} = ev_r;
    assign ubm_sel_we  = swe_r;
    assign ubm_sel_val = (swe_r & sval_r) | (~swe_r & {4{idle_r}});

    // kinds: 0 partial, 1 tx zero, 2 tx timeout, 3 rx zero, 4 uart err, 5 rx timeout
    task automatic pulse(input int kind, input int ch);
        @(posedge clk);
        ev_r[kind*2+ch] <= 1'b1;
        @(posedge clk);
        ev_r <= 12'h000;
    endtask

    // buffer manager hands the next buffer to a continuous channel
    task automatic set_sel(input int ch, input logic v);
        @(posedge clk);
        swe_r[ch]  <= 1'b1;
        sval_r[ch] <= v;
        @(posedge clk);
        swe_r <= 4'h0;
    endtask
endmodule
`default_nettype wire

// File: testbench/uart_dma_channel_control_tb_top.sv
// testbench: wishbone register tests of the dma channel control
`timescale 1ns/10ps
`default_nettype none
module uart_dma_channel_control_tb_top;
    import udc_pkg::*;
    logic             clk;
    logic             reset_n;
    logic             wb_cyc_i;
    logic             wb_stb_i;
    logic             wb_we_i;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0]       wb_sel_i;
    logic [DAT_W-1:0] wb_dat_i;
    logic [DAT_W-1:0] wb_dat_o;
    logic             wb_ack_o;
    logic             irq_o;
    logic [1:0]       tx_pd, tx_cz, tx_to, rx_cz, rx_ue, rx_to;
    logic [3:0]       s_we, s_val, en, cont, sel, dupd;
    logic [11:0]      ptr;
    logic [3:0]       dupd_seen = 4'h0;
    int               n_errors;
    int               num_checks;

    udc_top uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .tx_partial_det(tx_pd),
        .tx_count_zero(tx_cz), .tx_timeout(tx_to), .rx_count_zero(rx_cz),
        .rx_uart_err(rx_ue), .rx_timeout(rx_to), .ubm_sel_we(s_we),
        .ubm_sel_val(s_val), .chan_en_o(en), .chan_cont_o(cont),
        .chan_sel_o(sel), .chan_ptr_o(ptr), .descr_update_o(dupd));

    udc_far_model far (.clk(clk), .tx_partial_det(tx_pd),
        .tx_count_zero(tx_cz), .tx_timeout(tx_to), .rx_count_zero(rx_cz),
        .rx_uart_err(rx_ue), .rx_timeout(rx_to), .ubm_sel_we(s_we),
        .ubm_sel_val(s_val));

    // 250 MHz clock
    always #2 clk = ~clk;

    // descriptor update is a one-cycle pulse; keep a sticky copy per channel
    always @(posedge clk) begin
        dupd_seen <= dupd_seen | dupd;
    end

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // classic cycle: hold until ack is sampled, then release
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xfer(a, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        clk = 1'b0; reset_n = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0;
        wb_we_i = 1'b0; wb_adr_i = 8'h00; wb_sel_i = 4'h1;
        wb_dat_i = 32'h00000000; n_errors = 0; num_checks = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        // reset values of the definition, tx status and interrupt status registers
        for (int i = 0; i < 4; i++) begin
            rd(OFS_DEF0 + 8'(4 * i), DEF_RST);
        end
        rd(OFS_TX_STAT0, STAT_RST);
        rd(OFS_TX_STAT0 + 8'h04, STAT_RST);
        rd(OFS_IRQ_STAT, 8'h00);
        $display("test reset done");
        // tx status select bit: reserved bits stay zero, select shared
        wr(OFS_TX_STAT0, 8'hFF);
        rd(OFS_TX_STAT0, 8'h10);
        rd(OFS_DEF0, 8'h18);
        chk({7'h00, sel[0]}, 8'h01);
        wr(OFS_TX_STAT0, 8'h00);
        $display("test tx select done");
        // write guard and pointer on receive channel 2
        wr(8'h10, 8'h17);
        rd(8'h10, 8'h1F);
        chk({5'h00, ptr[8:6]}, 8'h07);
        chk({7'h00, sel[2]}, 8'h01);
        wr(8'h10, 8'h0A);
        rd(8'h10, 8'h1A);
        wr(8'h10, 8'h05);
        rd(8'h10, 8'h0D);
        $display("test guard done");
        // partial packet with completion interrupt off
        wr(OFS_DEF0, 8'h88);
        far.pulse(0, 0);
        idle(3);
        chk({7'h00, en[0]}, 8'h01);
        rd(OFS_TX_STAT0, 8'h01);
        rd(OFS_TX_STAT0 + 8'h04, 8'h00);
        rd(OFS_TX_COMP, 8'h00);
        wr(OFS_TX_STAT0, 8'h00);
        rd(OFS_TX_STAT0, 8'h01);
        wr(OFS_TX_STAT0, 8'h01);
        rd(OFS_TX_STAT0, 8'h00);
        // time-out on tx1 is then overridden by a short packet
        far.pulse(2, 1);
        rd(OFS_TX_COMP, 8'h02);
        far.pulse(0, 1);
        rd(OFS_TX_COMP, 8'h00);
        rd(OFS_TX_STAT0 + 8'h04, 8'h01);
        $display("test partial done");
        // burst receive ends on zero count and interrupts
        wr(OFS_IRQ_MASK, 8'h0F);
        wr(8'h10, 8'hC8);
        far.pulse(3, 0);
        idle(3);
        chk({7'h00, en[2]}, 8'h00);
        chk({7'h00, irq_o}, 8'h01);
        rd(OFS_IRQ_STAT, 8'h04);
        wr(OFS_IRQ_STAT, 8'h04);
        idle(2);
        chk({7'h00, irq_o}, 8'h00);
        chk({4'h0, dupd_seen}, 8'h04);
        $display("test burst done");
        // uart error halts silently, time-out halts with interrupt
        wr(8'h14, 8'hC8);
        far.pulse(4, 1);
        idle(3);
        chk({7'h00, en[3]}, 8'h00);
        rd(OFS_IRQ_STAT, 8'h00);
        wr(OFS_IRQ_MASK, 8'h00);
        wr(8'h14, 8'hC8);
        far.pulse(5, 1);
        idle(3);
        chk({7'h00, en[3]}, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        rd(OFS_IRQ_STAT, 8'h08);
        wr(OFS_IRQ_MASK, 8'h08);
        idle(2);
        chk({7'h00, irq_o}, 8'h01);
        wr(OFS_IRQ_STAT, 8'h08);
        idle(2);
        chk({7'h00, irq_o}, 8'h00);
        $display("test halt done");
        // continuous mode ignores zero count, manager drives select
        wr(8'h14, 8'hA0);
        far.pulse(3, 1);
        far.set_sel(3, 1'b1);
        idle(2);
        chk({7'h00, en[3]}, 8'h01);
        chk({7'h00, sel[3]}, 8'h01);
        chk({7'h00, cont[3]}, 8'h01);
        chk({4'h0, dupd_seen}, 8'h0C);
        rd(8'h3C, 8'h00);
        $display("test continuous done");
        end_of_test();
    end
endmodule
`default_nettype wire
